// [src/bhi_host_if.sv]
/*
 Host-facing logic of the baseband processor: four-wire serial control
 port with its register array, receive-ready handshake, receive standby,
 transmit chip output and test port.
 Assumes the serial clock is at most an eighth of clk_sys so that the
 three-flop sampling sees every edge; datapath strobes share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Ready output high marks received data start
// - Ready rises once frame delimiter is detected
// - Ready drops on enable loss or header error
// - Enable low keeps receiver and converters off
// - Eight address bits then eight data bits
// - Every serial byte moves MSB first
// - Data pin driven only while direction reads
// - Serial data captured on serial clock rise
// - Serial clock treated as unrelated to clk_sys
// - Direction high reads, low writes
// - Chip select high ignores all port pins
// - Chip select leaves transmit and receive alone
// - Reset disables transmit, receive; enters standby
// - Reset never touches stored configuration
// - Chip clocks derived from clk_sys by two/four
// - Transmit I and Q outputs at chip rate
// - Test port shows a chosen internal value
// - Chip select high restarts the port sequencer
// - Address least significant bit is ignored
// - Serial rise samples and launches read data
module bhi_host_if
    import bhi_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Control port pins
    input  wire logic       ctrl_cs_n,
    input  wire logic       ctrl_sclk,
    input  wire logic       ctrl_rw,
    input  wire logic       ctrl_serial_io_i,
    output logic            ctrl_serial_io_o,
    output logic            ctrl_serial_io_oe,
    // Receive handshake
    input  wire logic       rx_enable_in,
    input  wire logic       sfd_detect,
    input  wire logic       header_error,
    output logic            rx_frame_ready,
    output logic            rx_adc_enable,
    // Transmit side
    input  wire logic       tx_enable_in,
    input  wire bhi_chip_t  tx_chip_in,
    output logic            tx_active,
    output logic            chip_strobe,
    output logic            tx_inphase_out,
    output logic            tx_quadrature_out,
    // Power and test
    output logic            power_standby,
    output logic [7:0]      test_port
);
    ////////////////////////////////////////////////////////////////////////
    // Pin sampling

    bhi_ctrl_pins_t pins_raw;
    bhi_ctrl_pins_t pins_s;
    logic [1:0]     en_s;

    assign pins_raw = '{cs_n: ctrl_cs_n, sclk: ctrl_sclk, rw: ctrl_rw,
                        sd: ctrl_serial_io_i};

    // Serial pins arrive on their own clock
    bhi_pin_sync #(.W(4), .RST(PINS_RST)) u_ctrl_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  (pins_raw),
        .pin_out (pins_s)
    );

    // Enables come from the host pins as well
    bhi_pin_sync #(.W(2), .RST(2'h0)) u_en_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  ({rx_enable_in, tx_enable_in}),
        .pin_out (en_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial control port

    // Register address with its spare low bit dropped
    function automatic logic [IDX_W-1:0] reg_idx(input logic [7:0] a);
        return a[7:1];
    endfunction

    // Configuration store: deliberately no reset, so a master
    // reset leaves every setting where software put it
    logic [DATA_W-1:0] regs [REG_DEPTH];

    logic       sclk_prev_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] adr_q;
    logic [7:0] adr_d;
    logic [7:0] dat_q;
    logic [7:0] dat_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic       oe_q;
    logic       sel;
    logic       rise;
    logic       adr_done;
    logic       wr_fire;
    logic [7:0] adr_full;
    logic [7:0] dat_full;

    // Port decode on synchronised pins, some four cycles late
    assign sel      = ~pins_s.cs_n;
    assign rise     = sel & pins_s.sclk & ~sclk_prev_q;
    assign adr_full = {adr_q[6:0], pins_s.sd};
    assign dat_full = {dat_q[6:0], pins_s.sd};
    assign adr_done = rise & (cnt_q == CNT_LAST_ADR);
    assign wr_fire  = rise & (cnt_q == CNT_LAST_DAT) & ~pins_s.rw;

    // Sequencer next state; deselect forces a restart
    assign cnt_d = !sel ? CNT_RST
                 : rise ? 4'(cnt_q + 4'h1) : cnt_q;
    assign adr_d = (rise && cnt_q <= CNT_LAST_ADR) ? adr_full : adr_q;
    assign dat_d = (rise && cnt_q > CNT_LAST_ADR) ? dat_full : dat_q;
    // Read byte loaded on the last address rise, shifted on later rises
    assign rd_d  = adr_done ? regs[reg_idx(adr_full)]
                 : rise ? {rd_q[6:0], 1'b0} : rd_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q <= 1'b0;
            cnt_q       <= CNT_RST;
            adr_q       <= BYTE_RST;
            dat_q       <= BYTE_RST;
            rd_q        <= BYTE_RST;
            oe_q        <= 1'b0;
        end else begin
            sclk_prev_q <= pins_s.sclk;
            cnt_q       <= cnt_d;
            adr_q       <= adr_d;
            dat_q       <= dat_d;
            rd_q        <= rd_d;
            oe_q        <= sel & pins_s.rw;
        end
    end

    // Writes already sit in clk_sys here, so no extra crossing
    always_ff @(posedge clk_sys) begin
        if (wr_fire) begin
            regs[reg_idx(adr_q)] <= dat_full;
        end
    end

    // Data and enable both leave flops, so the pin never glitches
    assign ctrl_serial_io_o  = rd_q[7];
    assign ctrl_serial_io_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive handshake

    logic rdy_q;
    logic rdy_d;
    logic adc_q;

    // Drop wins over a delimiter seen in the same cycle
    assign rdy_d = (!en_s[1] || header_error) ? 1'b0
                 : sfd_detect ? 1'b1 : rdy_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdy_q <= 1'b0;
            adc_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
            adc_q <= en_s[1];
        end
    end

    // Receive outputs straight from their flops
    assign rx_frame_ready = rdy_q;
    assign rx_adc_enable  = adc_q;

    ////////////////////////////////////////////////////////////////////////
    // Chip clock divider and transmit outputs

    logic [1:0] div_q;
    logic       div4;
    logic       stb;
    logic       stb_q;
    logic       txa_q;
    bhi_chip_t  chip_q;

    // Bit 0 of the divider register picks divide by four
    assign div4 = regs[IDX_CLK_DIV][0];
    assign stb  = div4 ? (div_q == DIV_LAST4)
                       : (div_q[0] == DIV_LAST2[0]);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= DIV_RST;
            stb_q  <= 1'b0;
            txa_q  <= 1'b0;
            chip_q <= '0;
        end else begin
            div_q  <= 2'(div_q + 2'h1);
            stb_q  <= stb;
            txa_q  <= en_s[0];
            if (stb) begin
                chip_q <= en_s[0] ? tx_chip_in : '0;
            end
        end
    end

    // Chip pair stands unchanged between strobes
    assign tx_active         = txa_q;
    assign chip_strobe       = stb_q;
    assign tx_inphase_out    = chip_q.i;
    assign tx_quadrature_out = chip_q.q;

    ////////////////////////////////////////////////////////////////////////
    // Standby and test port

    logic       stby_q;
    logic [7:0] test_q;
    logic [7:0] test_d;
    logic [7:0] tsel;

    // Select 0 shows port state, otherwise the addressed register
    assign tsel   = regs[IDX_TEST_SEL];
    assign test_d = (tsel == BYTE_RST)
                  ? {rdy_q, adc_q, txa_q, oe_q, cnt_q}
                  : regs[reg_idx(tsel)];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stby_q <= 1'b1;
            test_q <= BYTE_RST;
        end else begin
            stby_q <= 1'b0;
            test_q <= test_d;
        end
    end

    // Standby stays up for the whole reset
    assign power_standby = stby_q;
    assign test_port     = test_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Receive handshake
    rdy_rise_a: assert property ($rose(rx_frame_ready) |->
        $past(sfd_detect) && $past(en_s[1])) else $error("ready rose late");
    rdy_drop_a: assert property (!en_s[1] |=> !rx_frame_ready)
        else $error("ready held without enable");
    hdr_err_a: assert property (header_error |=> !rx_frame_ready)
        else $error("ready held after header error");
    adc_off_a: assert property (!en_s[1] |=> !rx_adc_enable)
        else $error("converters on in standby");

    // Serial control port
    oe_dir_a: assert property (ctrl_serial_io_oe |->
        $past(pins_s.rw) && !$past(pins_s.cs_n))
        else $error("data pin driven on write");
    oe_write_a: assert property (!pins_s.rw |=>
        !ctrl_serial_io_oe) else $error("pin enabled with write direction");
    cs_quiet_a: assert property (pins_s.cs_n |=>
        !ctrl_serial_io_oe) else $error("pin driven while deselected");
    cs_restart_a: assert property (pins_s.cs_n |=> cnt_q == CNT_RST)
        else $error("sequencer not restarted");
    wr_slot_a: assert property (wr_fire |-> cnt_q == CNT_LAST_DAT &&
        !pins_s.rw) else $error("write outside data slot");
    rd_launch_a: assert property (rise && pins_s.rw &&
        cnt_q == 4'(CNT_LAST_ADR + 4'h1) |->
        ctrl_serial_io_o == regs[reg_idx(adr_q)][7])
        else $error("read MSB not launched");

    // Chip divider and transmit side
    div_two_a: assert property (!div4 && chip_strobe ##1 !div4 |->
        !chip_strobe ##1 chip_strobe) else $error("divide by two wrong");
    div_four_a: assert property (div4 ##1 div4 && chip_strobe ##1
        div4 [*3] |=> chip_strobe) else $error("divide by four wrong");
    div_gap_a: assert property (div4 ##1 div4 && chip_strobe ##1
        div4 |-> !chip_strobe ##1 !chip_strobe)
        else $error("divide by four strobe early");
    chip_hold_a: assert property (!stb |=> $stable(chip_q))
        else $error("chip output moved between strobes");
    tx_follow_a: assert property (tx_active == $past(en_s[0]))
        else $error("transmit enable not followed");

    // Main scenarios
    read_c:  cover property (rise && pins_s.rw && cnt_q == CNT_LAST_DAT);
    write_c: cover property (wr_fire);
    rdy_c:   cover property ($rose(rx_frame_ready));
    drop_c:  cover property (rx_frame_ready && header_error);
    div4_c:  cover property (div4 && chip_strobe);
endmodule
`default_nettype wire

// [src/bhi_pin_sync.sv]
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes asynchronous pins; the output moves only when stages two and
 three agree, so a single-cycle glitch past stage two is not taken.
*/
`timescale 1ns/1ps
`default_nettype none
module bhi_pin_sync
    import bhi_pkg::*;
#(
    parameter int         W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // Raw pins and filtered result
    input  wire logic [W-1:0] pin_in,
    output logic [W-1:0]      pin_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    // Bits whose last two stages match
    assign agree = ~(s2_q ^ s3_q);

    // Stage one feeds only stage two
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_q    <= RST;
            s2_q    <= RST;
            s3_q    <= RST;
            pin_out <= RST;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            pin_out <= (agree & s3_q) | (~agree & pin_out);
        end
    end
endmodule
`default_nettype wire

// [src/bhi_pkg.sv]
/*
 Package for the baseband host interface: widths, register file geometry,
 chosen register indexes, reset values and the pin bundle types.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bhi_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 8;
    localparam int          IDX_W        = 7;
    localparam int          REG_DEPTH    = 128;
    localparam int          SYNC_STAGES  = 3;
    localparam int          CLK_SYS_HZ   = 25000000;
    localparam int          SCLK_MAX_HZ  = 11000000;
    // Serial bit count: 8 address bits then 8 data bits
    localparam logic [3:0]  CNT_LAST_ADR = 4'h7;
    localparam logic [3:0]  CNT_LAST_DAT = 4'hf;
    localparam logic [3:0]  CNT_RST      = 4'h0;
    // Register indexes that steer local logic
    localparam logic [6:0]  IDX_TEST_SEL = 7'h10;
    localparam logic [6:0]  IDX_CLK_DIV  = 7'h11;
    // Chip strobe divider
    localparam logic [1:0]  DIV_LAST2    = 2'h1;
    localparam logic [1:0]  DIV_LAST4    = 2'h3;
    localparam logic [1:0]  DIV_RST      = 2'h0;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [3:0]  PINS_RST     = 4'h9;

    // Control port pins, sampled as one bundle
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic rw;
        logic sd;
    } bhi_ctrl_pins_t;

    // Transmit chip pair
    typedef struct packed {
        logic i;
        logic q;
    } bhi_chip_t;
endpackage

// [testbench/bhi_host_model.sv]
/*
 Host controller model for the four-wire serial control port.
 Assumes the bench resolves the shared data line and calls xfer.
*/
`timescale 1ns/1ps
`default_nettype none
module bhi_host_model
    import bhi_pkg::*;
#(
    parameter int HALF = 8
) (
    // Clock and resolved data line
    input  wire logic clk_sys,
    input  wire logic sd_line,
    // Driven port pins
    output var logic  cs_n,
    output var logic  sclk,
    output var logic  rw,
    output var logic  sd,
    output var logic  sd_oe
);
    // Idle: deselected, serial clock standing low
    initial begin
        cs_n  = 1'b1;
        sclk  = 1'b0;
        rw    = 1'b0;
        sd    = 1'b0;
        sd_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame; sel low keeps the port deselected, nbits < 16 cuts short.
    // Half period of HALF cycles keeps sclk well under both speed limits.
    task automatic xfer(input logic rd, input logic [15:0] aw,
                        input int nbits, input logic sel,
                        output logic [7:0] rdat);
        rdat = 8'h00;
        @(posedge clk_sys);
        cs_n <= ~sel;
        for (int k = 0; k < nbits; k++) begin
            sd_oe <= !(rd && k >= 8);
            sd    <= aw[15-k];
            // Direction turns only after the address, so the port
            // never drives the line while our address bits are on it
            if (k == 8)
                rw <= rd;
            repeat (HALF) @(posedge clk_sys);
            // Read bit launched at the previous rise, taken before the next
            if (rd && k >= 8)
                rdat = {rdat[6:0], sd_line};
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk_sys);
        cs_n  <= 1'b1;
        sd_oe <= 1'b0;
        rw    <= 1'b0;
        repeat (12) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 Self-checking bench: serial register access, receive handshake,
 transmit chips, test port and reset.
 Assumes bhi_host_model drives the control port pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bhi_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       arst_n  = 1'b0;
    logic       rx_en   = 1'b0;
    logic       sfd     = 1'b0;
    logic       hdr_err = 1'b0;
    logic       tx_en   = 1'b0;
    bhi_chip_t  chip    = '0;
    logic       junk_q  = 1'b0;
    logic       quiet   = 1'b0;
    logic [7:0] mem [128];
    int         mismatches  = 0;
    int         checks_done = 0;
    int         seed        = 32'hfb985aa3;
    wire logic  h_cs_n, h_sclk, h_rw, h_sd, h_oe, d_o, d_oe, sd_line;
    wire logic  rdy, adc, tx_act, strobe, tx_i, tx_q, standby;
    wire logic [7:0] tpo;

    // Released line shows a toggling pattern, never the last value
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) junk_q <= ~junk_q;
    assign sd_line = d_oe ? d_o : (h_oe ? h_sd : junk_q);

    bhi_host_model u_host (.clk_sys(clk_sys), .sd_line(sd_line),
        .cs_n(h_cs_n), .sclk(h_sclk), .rw(h_rw), .sd(h_sd), .sd_oe(h_oe));

    bhi_host_if u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .ctrl_cs_n(h_cs_n), .ctrl_sclk(h_sclk), .ctrl_rw(h_rw),
        .ctrl_serial_io_i(sd_line), .ctrl_serial_io_o(d_o),
        .ctrl_serial_io_oe(d_oe), .rx_enable_in(rx_en),
        .sfd_detect(sfd), .header_error(hdr_err), .rx_frame_ready(rdy),
        .rx_adc_enable(adc), .tx_enable_in(tx_en), .tx_chip_in(chip),
        .tx_active(tx_act), .chip_strobe(strobe), .tx_inphase_out(tx_i),
        .tx_quadrature_out(tx_q), .power_standby(standby),
        .test_port(tpo));

    ////////////////////////////////////////////////////////////////////////
    // Pin must stay released while writing or deselected
    always @(posedge clk_sys) #10 if (quiet && d_oe !== 1'b0) begin
        mismatches++;
        $display("wrong value at %0t: data pin driven", $time);
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Settled sampling point after n edges
    task automatic pause(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        quiet = 1'b1;
        u_host.xfer(1'b0, {a, d}, 16, 1'b1, r);
        quiet = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(1'b1, {a, 8'h00}, 16, 1'b1, r);
        cmp(r, e);
    endtask

    // One-cycle delimiter or header error pulse
    task automatic rx_pulse(input logic err);
        @(posedge clk_sys);
        sfd     <= !err;
        hdr_err <= err;
        @(posedge clk_sys);
        sfd     <= 1'b0;
        hdr_err <= 1'b0;
        pause(2);
    endtask

    function automatic logic [7:0] exp_strobes(input logic div4, input int n);
        return div4 ? 8'(n / 4) : 8'(n / 2);
    endfunction

    function automatic logic [7:0] exp_chips(input logic en, input bhi_chip_t c);
        return en ? {6'h00, c.i, c.q} : 8'h00;
    endfunction

    task automatic conclude;
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        $display("wrong value at %0t: run did not finish", $time);
        conclude;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] r, v;
        logic [6:0] idx;
        int n;
        // Reset held eleven cycles
        pause(10);
        cmp({6'h00, standby, rdy}, 8'h02);
        cyc(1);
        arst_n <= 1'b1;
        cyc(6);
        wr(8'h22, 8'h00);
        wr(8'h20, 8'h00);
        // Write through the even address, read through the odd alias
        for (int t = 0; t < 6; t++) begin
            idx = (t == 0) ? 7'h7f : 7'($random(seed));
            if (idx[6:1] == 6'h08)
                idx = 7'h12;
            v = (t == 0) ? 8'h81 : 8'($random(seed));
            mem[idx] = v;
            wr({idx, 1'b0}, v);
            rd_chk({idx, 1'b1}, v);
        end
        // Deselected and cut-short frames leave the register alone
        quiet = 1'b1;
        u_host.xfer(1'b0, {idx, 1'b0, ~v}, 16, 1'b0, r);
        u_host.xfer(1'b1, {idx, 1'b1, 8'h00}, 16, 1'b0, r);
        u_host.xfer(1'b0, {idx, 1'b0, ~v}, 11, 1'b1, r);
        quiet = 1'b0;
        rd_chk({idx, 1'b1}, v);
        wr(8'hfe, 8'h5a);
        mem[7'h7f] = 8'h5a;
        wr(8'h20, 8'hfe);
        pause(8);
        cmp(tpo, mem[7'h7f]);
        wr(8'h20, 8'h00);
        // Receive handshake; serial traffic must not disturb it
        rx_en <= 1'b1;
        pause(8);
        cmp({7'h00, adc}, 8'h01);
        rx_pulse(1'b0);
        cmp({7'h00, rdy}, 8'h01);
        cmp(tpo, 8'hc0);
        rd_chk({idx, 1'b1}, mem[idx]);
        cmp({7'h00, rdy}, 8'h01);
        rx_pulse(1'b1);
        cmp({7'h00, rdy}, 8'h00);
        rx_pulse(1'b0);
        cyc(1);
        rx_en <= 1'b0;
        pause(8);
        cmp({6'h00, rdy, adc}, 8'h00);
        rx_pulse(1'b0);
        cmp({7'h00, rdy}, 8'h00);
        // Chip strobe rate for both dividers, then chip loading
        for (int dv = 0; dv < 2; dv++) begin
            wr(8'h22, 8'(dv));
            tx_en <= 1'b1;
            pause(8);
            cmp({7'h00, tx_act}, 8'h01);
            n = 0;
            for (int k = 0; k < 40; k++) begin
                @(negedge clk_sys);
                n += int'(strobe === 1'b1);
            end
            cmp(8'(n), exp_strobes(dv[0], 40));
            for (int k = 0; k < 3; k++) begin
                cyc(1);
                chip <= 2'($random(seed));
                pause(8);
                cmp({6'h00, tx_i, tx_q}, exp_chips(1'b1, chip));
            end
            cyc(1);
            tx_en <= 1'b0;
            pause(8);
            cmp({6'h00, tx_i, tx_q}, exp_chips(1'b0, chip));
        end
        // Reset in mid-run: functions off, stored contents kept
        cyc(1);
        rx_en <= 1'b1;
        tx_en <= 1'b1;
        rx_pulse(1'b0);
        cyc(1);
        arst_n <= 1'b0;
        pause(3);
        cmp({4'h0, standby, rdy, adc, tx_act}, 8'h08);
        cyc(1);
        arst_n <= 1'b1;
        cyc(6);
        cmp({7'h00, standby}, 8'h00);
        rd_chk({idx, 1'b1}, mem[idx]);
        conclude;
    end
endmodule
`default_nettype wire
